// File: rtl/csef_pkg.sv
// Constants shared by the CAN status and event flag block
package csef_pkg;
  // Opcodes seen on the host command port
  localparam logic [7:0] OP_FAULT_RD    = 8'hdc;
  localparam logic [7:0] OP_ALERT_RD    = 8'hde;
  localparam logic [7:0] OP_ENABLE_WR   = 8'h1c;
  localparam logic [7:0] OP_ENABLE_RD   = 8'he4;
  localparam logic [7:0] OP_MSGSTAT_RD  = 8'hd2;
  // Message status layout
  localparam int MS_HIT_LSB   = 4;
  localparam int MS_LABEL_LSB = 2;
  localparam int MS_TXST_LSB  = 0;
  // Bus fault layout
  localparam int BF_DETACHED  = 7;
  localparam int BF_TX_PASS   = 6;
  localparam int BF_RX_PASS   = 5;
  localparam int BF_BIT       = 4;
  localparam int BF_FORM      = 3;
  localparam int BF_CRC       = 2;
  localparam int BF_ACK       = 1;
  localparam int BF_STUFF     = 0;
  localparam logic [7:0] BF_CLEAR_ON_READ = 8'h1f;
  // Alert flag layout
  localparam int AF_RAW       = 7;
  localparam int AF_QUEUED    = 6;
  localparam int AF_SENT      = 5;
  localparam int AF_PROTO     = 4;
  localparam int AF_MODE      = 3;
  localparam int AF_RESUME    = 2;
  localparam int AF_FILT1     = 1;
  localparam int AF_FILT0     = 0;
  // Reset values
  localparam logic [7:0] RST_ALERT_FLAGS   = 8'h00;
  localparam logic [7:0] RST_ALERT_ENABLES = 8'h00;
  localparam logic [7:0] RST_BUS_FAULT     = 8'h00;
  localparam logic [3:0] RST_HIT_CODE      = 4'h0;
  localparam logic [2:0] RST_MODE          = 3'h4;
  // Error counter thresholds
  localparam logic [8:0] PASSIVE_MIN  = 9'h080;
  localparam logic [8:0] PASSIVE_MAX  = 9'h0ff;
  // Recovery run of recessive bits, 128 x 11
  localparam int RECOVERY_GROUPS = 128;
  localparam int RECOVERY_BITS   = 11;
  localparam logic [10:0] RECOVERY_RUN = 11'(RECOVERY_GROUPS * RECOVERY_BITS);
  // Transmit state encodings
  localparam logic [1:0] TXST_OFF     = 2'h0;
  localparam logic [1:0] TXST_EMPTY   = 2'h1;
  localparam logic [1:0] TXST_WAIT    = 2'h2;
  localparam logic [1:0] TXST_SENDING = 2'h3;
  typedef enum logic [0:0] {
    MODE_IDLE  = 1'b0,
    MODE_DRAIN = 1'b1
  } csef_mode_e;
endpackage : csef_pkg

// File: rtl/csef_status_flags.sv
// CAN status, bus fault and alert flag registers with host alert output
`timescale 1ns/1ps
// What this block does
// RL1 - Filters checked lowest number first; the lowest matching filter is reported.
// RL2 - Filter hit code reads 0000 on no match, else 1 and filter number.
// RL3 - Status bits 3-2 hold low two tag bits of last good transmission.
// RL4 - Transmit state: 00 off, 01 empty queue, 10 waiting, 11 sending.
// RL5 - Bus fault bits clear at power-up only; later resets keep them.
// RL6 - Host read of bus fault clears bits 4-0; state bits stay.
// RL7 - Detached bit sets when count exceeds 255; clears after 128x11 recessive bits.
// RL8 - Transmit passive bit set while transmit count is 128 to 255.
// RL9 - Receive passive bit set while receive count is 128 to 255.
// RL10 - Bit 4 sets when own transmitted bit reads back opposite.
// RL11 - Bits 3,2,1,0 set on form, checksum, acknowledge, stuffing faults.
// RL12 - Alert output high and latched while any enabled flag is set.
// RL13 - Reading alert flags clears all flags and releases the output.
// RL14 - Two spare pins mirror chosen alert flags per routing setting.
// RL15 - Flag 7 sets on any valid frame in the temporary buffer.
// RL16 - Flag 6 sets when a filtered frame moves into the receive queue.
// RL17 - Flag 5 sets on each successful transmission.
// RL18 - Flag 4 sets on any protocol fault.
// RL19 - Flag 3 sets on mode change, applied only after queue drains.
// RL20 - Flag 2 sets when bus activity wakes the device from sleep.
// RL21 - Flags 1 and 0 set when filter one or zero passes a frame; flag 1 sets only if filter zero does not also pass.
// RL22 - Enable register, write 0x1c read 0xe4, one bit per flag, reset clear.
// RL23 - Host reads faults with 0xdc, flags with 0xde; neither is writable.
// RL24 - An event in the clearing read's cycle stays set.
module csef_status_flags (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       por_b,
  // Host command port from the serial front end
  input  wire logic       cmd_rd,
  input  wire logic       cmd_wr,
  input  wire logic [7:0] cmd_op,
  input  wire logic [7:0] cmd_wdata,
  output logic [7:0]      cmd_rdata,
  output logic            alert_out,
  // Receive path events
  input  wire logic       raw_frame_arrived,
  input  wire logic       frame_filtered,
  input  wire logic [7:0] filter_matches,
  input  wire logic       filter_enable,
  // Transmit path
  input  wire logic       send_done,
  input  wire logic [1:0] send_tag,
  input  wire logic       transmit_allow,
  input  wire logic       tx_queue_empty,
  input  wire logic       tx_active,
  // Protocol engine
  input  wire logic       bit_mismatch,
  input  wire logic       form_violation,
  input  wire logic       checksum_fault,
  input  wire logic       acknowledge_fault,
  input  wire logic       stuffing_fault,
  input  wire logic [8:0] transmit_fault_count,
  input  wire logic [7:0] inbound_fault_count,
  input  wire logic       bit_sampled,
  input  wire logic       bit_recessive,
  input  wire logic       wake_from_bus,
  // Mode change request
  input  wire logic       mode_req,
  input  wire logic [2:0] mode_req_value,
  output logic [2:0]      active_mode,
  // Spare outputs
  input  wire logic [5:0] spare_output_routing,
  output logic            spare_output_one,
  output logic            spare_output_two
);
  import csef_pkg::*;

  logic [7:0]  alert_flags;
  logic [7:0]  alert_enables;
  logic [7:0]  bus_fault_flags;
  logic [3:0]  filter_match_code;
  logic [1:0]  last_sent_label;
  logic [1:0]  tx_state_code;
  logic [10:0] recessive_run;
  logic [2:0]  pending_mode;
  csef_mode_e  mode_state;
  logic [3:0]  next_hit_code;
  logic [7:0]  alert_set;
  logic [7:0]  fault_set;
  logic        mode_applied;
  logic        rd_fault;
  logic        rd_alert;
  logic        any_fault;

  assign rd_fault  = cmd_rd && (cmd_op == OP_FAULT_RD);
  assign rd_alert  = cmd_rd && (cmd_op == OP_ALERT_RD);
  assign any_fault = bit_mismatch | form_violation | checksum_fault
                   | acknowledge_fault | stuffing_fault;

  // Lowest numbered match wins, so scan from the top down
  always_comb begin
    next_hit_code = 4'h0; // [RL2]
    for (int i = 7; i >= 0; i--) begin
      if (filter_matches[i]) begin
        next_hit_code = {1'b1, 3'(i)}; // [RL1] [RL2]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      filter_match_code <= RST_HIT_CODE;
    end else if (frame_filtered && filter_enable) begin
      filter_match_code <= next_hit_code; // [RL1]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_sent_label <= 2'h0;
    end else if (send_done) begin
      last_sent_label <= send_tag; // [RL3]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_code <= TXST_OFF;
    end else if (!transmit_allow) begin
      tx_state_code <= TXST_OFF; // [RL4]
    end else if (tx_active) begin
      tx_state_code <= TXST_SENDING; // [RL4]
    end else if (tx_queue_empty) begin
      tx_state_code <= TXST_EMPTY; // [RL4]
    end else begin
      tx_state_code <= TXST_WAIT; // [RL4]
    end
  end

  // Recovery counter; any dominant bit restarts the run
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      recessive_run <= 11'h000;
    end else if (!bus_fault_flags[BF_DETACHED]) begin
      recessive_run <= 11'h000;
    end else if (bit_sampled) begin
      recessive_run <= bit_recessive ? recessive_run + 11'h001 : 11'h000; // [RL7]
    end
  end

  always_comb begin
    fault_set = 8'h00;
    fault_set[BF_BIT]   = bit_mismatch; // [RL10]
    fault_set[BF_FORM]  = form_violation; // [RL11]
    fault_set[BF_CRC]   = checksum_fault; // [RL11]
    fault_set[BF_ACK]   = acknowledge_fault; // [RL11]
    fault_set[BF_STUFF] = stuffing_fault; // [RL11]
  end

  // Power-on reset only, so faults survive a soft reset for diagnosis
  always_ff @(posedge clk or negedge por_b) begin
    if (!por_b) begin
      bus_fault_flags <= RST_BUS_FAULT; // [RL5]
    end else begin
      bus_fault_flags[BF_TX_PASS] <= (transmit_fault_count >= PASSIVE_MIN)
                                  && (transmit_fault_count <= PASSIVE_MAX); // [RL8]
      bus_fault_flags[BF_RX_PASS] <= {1'b0, inbound_fault_count} >= PASSIVE_MIN; // [RL9]
      if (transmit_fault_count > PASSIVE_MAX) begin
        bus_fault_flags[BF_DETACHED] <= 1'b1; // [RL7]
      end else if (bit_sampled && bit_recessive
                   && recessive_run == RECOVERY_RUN - 11'h001) begin
        bus_fault_flags[BF_DETACHED] <= 1'b0; // [RL7]
      end
      // Set wins over the read clear
      bus_fault_flags[4:0] <= (bus_fault_flags[4:0] & ~({5{rd_fault}}
                              & BF_CLEAR_ON_READ[4:0])) | fault_set[4:0]; // [RL6] [RL24]
    end
  end

  // Mode change waits until the transmit queue has drained
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_state   <= MODE_IDLE;
      pending_mode <= RST_MODE;
      active_mode  <= RST_MODE;
    end else begin
      case (mode_state)
        MODE_IDLE: begin
          if (mode_req) begin
            pending_mode <= mode_req_value;
            mode_state   <= MODE_DRAIN;
          end
        end
        MODE_DRAIN: begin
          if (mode_req) begin
            pending_mode <= mode_req_value;
          end else if (tx_queue_empty && !tx_active) begin
            active_mode <= pending_mode; // [RL19]
            mode_state  <= MODE_IDLE;
          end
        end
        default: mode_state <= MODE_IDLE;
      endcase
    end
  end

  assign mode_applied = (mode_state == MODE_DRAIN) && !mode_req
                        && tx_queue_empty && !tx_active;

  always_comb begin
    alert_set = 8'h00;
    alert_set[AF_RAW]    = raw_frame_arrived; // [RL15]
    alert_set[AF_QUEUED] = frame_filtered; // [RL16]
    alert_set[AF_SENT]   = send_done; // [RL17]
    alert_set[AF_PROTO]  = any_fault; // [RL18]
    alert_set[AF_MODE]   = mode_applied; // [RL19]
    alert_set[AF_RESUME] = wake_from_bus; // [RL20]
    alert_set[AF_FILT1]  = frame_filtered && filter_enable
                           && filter_matches[1] && !filter_matches[0]; // [RL21]
    alert_set[AF_FILT0]  = frame_filtered && filter_enable && filter_matches[0]; // [RL21]
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_flags <= RST_ALERT_FLAGS;
    end else begin
      alert_flags <= (rd_alert ? 8'h00 : alert_flags) | alert_set; // [RL13] [RL24]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_enables <= RST_ALERT_ENABLES; // [RL22]
    end else if (cmd_wr && cmd_op == OP_ENABLE_WR) begin
      alert_enables <= cmd_wdata; // [RL22]
    end
  end

  // Level output follows the enabled latched flags, dropped by the flag read or by an enable write that masks them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_out <= 1'b0;
    end else begin
      alert_out <= |(((rd_alert ? 8'h00 : alert_flags) | alert_set)
                     & alert_enables); // [RL12] [RL13]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      spare_output_one <= 1'b0;
      spare_output_two <= 1'b0;
    end else begin
      spare_output_one <= alert_flags[spare_output_routing[2:0]]; // [RL14]
      spare_output_two <= alert_flags[spare_output_routing[5:3]]; // [RL14]
    end
  end

  // Read data captured with the strobe; writes to read-only opcodes ignored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_rdata <= 8'h00;
    end else if (cmd_rd) begin
      case (cmd_op)
        OP_FAULT_RD:   cmd_rdata <= bus_fault_flags; // [RL23]
        OP_ALERT_RD:   cmd_rdata <= alert_flags; // [RL23]
        OP_ENABLE_RD:  cmd_rdata <= alert_enables; // [RL22]
        OP_MSGSTAT_RD: cmd_rdata <= {filter_match_code, last_sent_label, tx_state_code};
        default:       cmd_rdata <= 8'h00;
      endcase
    end
  end
endmodule : csef_status_flags

// File: tb/csef_checker.sv
// Assertion checker for the status and alert flag block
`timescale 1ns/1ps
module csef_checker
  import csef_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       cmd_rd,
  input wire logic       cmd_wr,
  input wire logic [7:0] cmd_op,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_rdata,
  input wire logic       alert_out,
  input wire logic       raw_frame_arrived,
  input wire logic       frame_filtered,
  input wire logic       send_done,
  input wire logic       wake_from_bus,
  input wire logic       mode_req,
  input wire logic       tx_queue_empty,
  input wire logic       tx_active,
  input wire logic       bit_mismatch,
  input wire logic       form_violation,
  input wire logic       checksum_fault,
  input wire logic       acknowledge_fault,
  input wire logic       stuffing_fault,
  input wire logic [8:0] transmit_fault_count,
  input wire logic [7:0] inbound_fault_count
);
  import csef_pkg::*;
  logic [7:0] en;
  logic       drain;
  wire        rd_alert = cmd_rd && cmd_op == OP_ALERT_RD;
  // Any event in the read cycle keeps a flag, so the clear check needs a quiet cycle
  wire        quiet    = !(raw_frame_arrived || frame_filtered || send_done || wake_from_bus
                        || bit_mismatch || form_violation || checksum_fault
                        || acknowledge_fault || stuffing_fault
                        || (drain && !mode_req && tx_queue_empty && !tx_active));
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Shadow of the enables, fed only by port traffic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) en <= 8'h00;
    else if (cmd_wr && cmd_op == OP_ENABLE_WR) en <= cmd_wdata;
  end
  // Shadow of a mode change waiting for the queue to drain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) drain <= 1'b0;
    else if (mode_req) drain <= 1'b1;
    else if (tx_queue_empty && !tx_active) drain <= 1'b0;
  end
  raw_alert_a: assert property (raw_frame_arrived && en[AF_RAW] |=> alert_out)
    else $error("alert missing after raw frame");
  sent_alert_a: assert property (send_done && en[AF_SENT] |=> alert_out)
    else $error("alert missing after send");
  alert_hold_a: assert property (alert_out && !cmd_rd && !cmd_wr |=> alert_out)
    else $error("alert dropped without read");
  read_clr_a: assert property (rd_alert && quiet |=> !alert_out)
    else $error("alert kept after flag read");
  keep_ev_a: assert property (rd_alert && raw_frame_arrived && en[AF_RAW] |=> alert_out)
    else $error("event lost in clearing read");
  en_read_a: assert property (cmd_rd && cmd_op == OP_ENABLE_RD |=> cmd_rdata == $past(en))
    else $error("enable readback wrong");
  tx_pass_a: assert property (cmd_rd && cmd_op == OP_FAULT_RD && $stable(transmit_fault_count)
    |=> cmd_rdata[BF_TX_PASS] == ($past(transmit_fault_count) inside {[128:255]}))
    else $error("transmit passive bit wrong");
  rx_pass_a: assert property (cmd_rd && cmd_op == OP_FAULT_RD && $stable(inbound_fault_count)
    |=> cmd_rdata[BF_RX_PASS] == $past(inbound_fault_count[7]))
    else $error("receive passive bit wrong");
  c_raw: cover property (raw_frame_arrived && en[AF_RAW] ##1 alert_out);
  c_clr: cover property (rd_alert ##1 !alert_out);
  c_keep: cover property (rd_alert && raw_frame_arrived);
endmodule : csef_checker

// File: tb/csef_host.sv
// Host model driving the command port
`timescale 1ns/1ps
module csef_host (
  input  wire logic       clk,
  input  wire logic [7:0] cmd_rdata,
  output logic            cmd_rd,
  output logic            cmd_wr,
  output logic [7:0]      cmd_op,
  output logic [7:0]      cmd_wdata
);
  initial begin
    cmd_rd = 1'b0;
    cmd_wr = 1'b0;
    cmd_op = 8'h00;
    cmd_wdata = 8'h00;
  end
  // Called just after an edge; idle cycle after each access avoids double drive
  task automatic xfer(input logic w, input logic [7:0] op, input logic [7:0] wd,
                      output logic [7:0] d);
    cmd_op = op;
    cmd_wdata = wd;
    cmd_rd = !w;
    cmd_wr = w;
    @(posedge clk);
    #5;
    cmd_rd = 1'b0;
    cmd_wr = 1'b0;
    cmd_op = ~op;
    cmd_wdata = ~wd;
    d = cmd_rdata;
    @(posedge clk);
    #5;
  endtask : xfer
endmodule : csef_host

// File: tb/test_csef_status_flags.sv
// Self-checking bench for the status and alert flag block
`timescale 1ns/1ps
module test_csef_status_flags;
  import csef_pkg::*;
  logic       clk, rst_b, por_b, bit_sampled, bit_recessive, cmd_rd, cmd_wr, alert_out;
  logic       spare_output_one, spare_output_two;
  logic [5:0] spare_output_routing;
  logic [2:0] active_mode;
  logic [7:0] cmd_op, cmd_wdata, cmd_rdata, ev, inbound_fault_count, d;
  logic [8:0] transmit_fault_count;
  logic [4:0] flt;
  logic [2:0] tsv;
  logic [1:0] tag;
  int         err_count, check_count, cyc;
  int         tv[7] = '{128, 255, 127, 0, 0, 0, 256};
  int         rv[7] = '{0, 0, 0, 128, 255, 127, 0};
  logic [7:0] pe[7] = '{8'h40, 8'h40, 8'h00, 8'h20, 8'h20, 8'h00, 8'h80};
  logic [2:0] ts[4] = '{3'b000, 3'b110, 3'b100, 3'b101};
  csef_status_flags i_csef_status_flags (
    .clk, .rst_b, .por_b, .cmd_rd, .cmd_wr, .cmd_op, .cmd_wdata, .cmd_rdata, .alert_out,
    .raw_frame_arrived(ev[7]), .frame_filtered(ev[6] | ev[1] | ev[0]),
    .filter_matches(ev[0] ? 8'hff : {5'h00, ev[1], ev[1], 1'b0}), .filter_enable(1'b1),
    .send_done(ev[5]), .send_tag(tag), .transmit_allow(tsv[2]), .tx_queue_empty(tsv[1]),
    .tx_active(tsv[0]), .bit_mismatch(flt[4]), .form_violation(flt[3]),
    .checksum_fault(flt[2]), .acknowledge_fault(flt[1]), .stuffing_fault(flt[0] | ev[4]),
    .transmit_fault_count, .inbound_fault_count, .bit_sampled, .bit_recessive,
    .wake_from_bus(ev[2]), .mode_req(ev[3]), .mode_req_value(3'h2), .active_mode,
    .spare_output_routing, .spare_output_one, .spare_output_two);
  csef_host i_csef_host (.clk, .cmd_rdata, .cmd_rd, .cmd_wr, .cmd_op, .cmd_wdata);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] op, input logic [7:0] e);
    i_csef_host.xfer(1'b0, op, 8'h00, d);
    chk($sformatf("op %h", op), e, d);
  endtask : rdc
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    {rst_b, por_b, bit_sampled, ev, flt, transmit_fault_count, inbound_fault_count} = '0;
    tsv = 3'b010;
    tag = 2'b10;
    bit_recessive = 1'b1;
    spare_output_routing = 6'h37;
    tick(3);
    {rst_b, por_b} = 2'b11;
    rdc(OP_ALERT_RD, 8'h00);
    rdc(OP_ENABLE_RD, 8'h00);
    rdc(OP_FAULT_RD, 8'h00);
    rdc(OP_MSGSTAT_RD, 8'h00);
    i_csef_host.xfer(1'b1, OP_ENABLE_WR, 8'hff, d);
    rdc(OP_ENABLE_RD, 8'hff);
    for (int k = 7; k >= 0; k--) begin
      ev = 8'h01 << k;
      tick(1);
      ev = 8'h00;
      tick(3);
      chk("alert", 8'h01, {7'h00, alert_out});
      chk("spare", k == 7 ? 8'h01 : (k == 6 || k < 2 ? 8'h02 : 8'h00),
          {6'h00, spare_output_two, spare_output_one});
      rdc(OP_ALERT_RD, (8'h01 << k) | (k < 2 ? 8'h40 : 8'h00));
      chk("alert", 8'h00, {7'h00, alert_out});
      if (k < 2) rdc(OP_MSGSTAT_RD, k ? 8'h98 : 8'h88);
    end
    $display("event flags done");
    for (int i = 0; i < 5; i++) begin
      flt = 5'h01 << i;
      tick(1);
      flt = 5'h00;
      rdc(OP_FAULT_RD, 8'h01 << i);
      rdc(OP_FAULT_RD, 8'h00);
    end
    rdc(OP_ALERT_RD, 8'h10);
    for (int i = 0; i < 7; i++) begin
      transmit_fault_count = 9'(tv[i]);
      inbound_fault_count = 8'(rv[i]);
      tick(2);
      rdc(OP_FAULT_RD, pe[i]);
    end
    transmit_fault_count = 9'h000;
    tick(2);
    rst_b = 1'b0;
    tick(1);
    rst_b = 1'b1;
    rdc(OP_FAULT_RD, 8'h80);
    rdc(OP_ENABLE_RD, 8'h00);
    bit_sampled = 1'b1;
    tick(1407);
    // One dominant bit restarts the recovery run
    bit_recessive = 1'b0;
    tick(1);
    bit_recessive = 1'b1;
    tick(1407);
    bit_sampled = 1'b0;
    rdc(OP_FAULT_RD, 8'h80);
    bit_sampled = 1'b1;
    tick(1);
    bit_sampled = 1'b0;
    tick(1);
    rdc(OP_FAULT_RD, 8'h00);
    $display("bus faults done");
    for (int j = 0; j < 4; j++) begin
      tsv = ts[j];
      tick(2);
      rdc(OP_MSGSTAT_RD, {6'h00, 2'(j)});
    end
    tsv = 3'b010;
    i_csef_host.xfer(1'b1, OP_ENABLE_WR, 8'h00, d);
    ev = 8'h80;
    tick(1);
    ev = 8'h00;
    tick(2);
    chk("masked alert", 8'h00, {7'h00, alert_out});
    i_csef_host.xfer(1'b1, OP_ALERT_RD, 8'hff, d);
    rdc(OP_ALERT_RD, 8'h80);
    rdc(8'h00, 8'h00);
    i_csef_host.xfer(1'b1, OP_ENABLE_WR, 8'hff, d);
    fork
      i_csef_host.xfer(1'b0, OP_ALERT_RD, 8'h00, d);
      begin
        ev = 8'h80;
        tick(1);
        ev = 8'h00;
      end
    join
    chk("overlap read", 8'h00, d);
    chk("alert", 8'h01, {7'h00, alert_out});
    rdc(OP_ALERT_RD, 8'h80);
    // Mode change held back while the transmitter still has work
    tsv = 3'b101;
    ev = 8'h08;
    tick(1);
    ev = 8'h00;
    tick(3);
    chk("mode held", {5'h00, RST_MODE}, {5'h00, active_mode});
    tsv = 3'b010;
    tick(2);
    chk("mode", 8'h02, {5'h00, active_mode});
    rdc(OP_ALERT_RD, 8'h08);
    $display("mask and overlap done");
    wrap_up();
  end
endmodule : test_csef_status_flags
bind csef_status_flags csef_checker i_csef_checker (.clk, .rst_b, .cmd_rd, .cmd_wr, .cmd_op,
  .cmd_wdata, .cmd_rdata, .alert_out, .raw_frame_arrived, .frame_filtered, .send_done,
  .wake_from_bus, .mode_req, .tx_queue_empty, .tx_active, .bit_mismatch, .form_violation,
  .checksum_fault, .acknowledge_fault, .stuffing_fault,
  .transmit_fault_count, .inbound_fault_count);
